// ===== rtl/strap_cfg_pkg.sv
// shared constants for the serial port pair strap configuration logic
package strap_cfg_pkg;

  // ---------------------------------------------------------------------------
  // topology
  // ---------------------------------------------------------------------------
  localparam int unsigned PAIR_COUNT = 8;      // even ports 0,2,..,14
  localparam int unsigned LANE_COUNT = 4;      // lanes a..d per pair

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned STRAP_HOLD_CYCLES = 10;  // strap stable after reset release
  localparam logic [3:0]  SAMPLE_EDGE       = 4'hA; // capture on the tenth edge

  // ---------------------------------------------------------------------------
  // apb register map (one word per pair, then a status word)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CLKSEL_BASE   = 8'h00;  // pair p at CLKSEL_BASE + 4*p
  localparam logic [7:0]  STATUS_ADDR   = 8'h20;  // sampled straps, all pairs
  localparam int unsigned OVR_EN_BIT    = 0;      // override enable
  localparam int unsigned OVR_VAL_BIT   = 1;      // override power-down value
  localparam logic [1:0]  CLKSEL_RESET  = 2'h0;   // override off after reset

  // ---------------------------------------------------------------------------
  // strap meanings
  // ---------------------------------------------------------------------------
  localparam logic MODE_FOUR_LANE = 1'b0;  // lane-mode strap 0
  localparam logic MODE_ONE_LANE  = 1'b1;  // lane-mode strap 1
  localparam logic MODE_DEFAULT   = 1'b0;  // pull-down value
  localparam logic PWRDN_DEFAULT  = 1'b1;  // pull-up value

endpackage : strap_cfg_pkg

// ===== rtl/pair_lane_cfg.sv
// per-pair lane routing and power decode from held strap values
`timescale 1ns/1ps
`default_nettype none

module pair_lane_cfg
  import strap_cfg_pkg::*;
(
  input  wire logic       lane_mode_i,      // held lane-mode strap
  input  wire logic       pair_pwrdn_i,     // effective pair power-down
  input  wire logic       odd_pwrdn_i,      // held odd port strap
  output logic            even_up_o,        // even port powered
  output logic            odd_up_o,         // odd port powered
  output logic            odd_avail_o,      // odd port usable
  output logic [3:0]      lane_pwr_o,       // transceiver lane power a..d
  output logic [3:0]      even_lane_sel_o,  // lanes owned by even port
  output logic [3:0]      odd_lane_sel_o    // lanes owned by odd port
);

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  always_comb begin
    // lane a always belongs to the even port
    even_lane_sel_o = 4'h1;
    odd_lane_sel_o  = 4'h0;
    if (lane_mode_i == MODE_FOUR_LANE) begin
      // one wide port: b, c, d join lane a
      even_lane_sel_o = 4'hF;
    end else begin
      // two narrow ports: lane b moves to the odd port, c and d idle
      odd_lane_sel_o = 4'h2;
    end
    odd_avail_o = (lane_mode_i == MODE_ONE_LANE);
    even_up_o   = !pair_pwrdn_i;
    // odd port is forced down by effective pair power-down or by four-lane mode
    odd_up_o    = !pair_pwrdn_i && !odd_pwrdn_i && odd_avail_o;
    // pair power acts on the whole macro at once
    lane_pwr_o  = {LANE_COUNT{!pair_pwrdn_i}};
  end

endmodule : pair_lane_cfg
`default_nettype wire

// ===== rtl/serial_port_lane_strap_config.sv
// strap sampling, apb override registers and per-pair configuration outputs
`timescale 1ns/1ps
`default_nettype none

module serial_port_lane_strap_config
  import strap_cfg_pkg::*;
(
  input  wire logic                    clk_i,             // core reference clock
  input  wire logic                    reset_i,           // async, active high
  input  wire logic                    test_mode_i,       // pins become outputs
  // strap pins; lane-mode and pair power-down split into in/out/enable, odd power-down input only
  input  wire logic [PAIR_COUNT-1:0]   pair_lane_mode_strap_i,
  input  wire logic [PAIR_COUNT-1:0]   pair_power_down_strap_i,
  input  wire logic [PAIR_COUNT-1:0]   odd_port_power_down_strap_i,
  input  wire logic [PAIR_COUNT-1:0]   strap_test_data_i,  // test drive value
  output logic      [PAIR_COUNT-1:0]   pair_lane_mode_strap_o,
  output logic      [PAIR_COUNT-1:0]   pair_lane_mode_strap_oe_o,
  output logic      [PAIR_COUNT-1:0]   pair_power_down_strap_o,
  output logic      [PAIR_COUNT-1:0]   pair_power_down_strap_oe_o,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // configuration towards macs and transceivers
  output logic                         cfg_valid_o,
  output logic      [PAIR_COUNT-1:0]   even_port_up_o,
  output logic      [PAIR_COUNT-1:0]   odd_port_up_o,
  output logic      [PAIR_COUNT-1:0]   odd_port_avail_o,
  output logic      [4*PAIR_COUNT-1:0] lane_power_o,
  output logic      [4*PAIR_COUNT-1:0] even_lane_sel_o,
  output logic      [4*PAIR_COUNT-1:0] odd_lane_sel_o
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [PAIR_COUNT-1:0] mode_meta;     // first stage, read by second only
  logic [PAIR_COUNT-1:0] mode_sync;     // usable mode strap
  logic [PAIR_COUNT-1:0] pwr_meta;
  logic [PAIR_COUNT-1:0] pwr_sync;
  logic [PAIR_COUNT-1:0] odd_meta;
  logic [PAIR_COUNT-1:0] odd_sync;

  // two flops per pin; reset values match the pad pulls
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_meta <= {PAIR_COUNT{MODE_DEFAULT}};
      mode_sync <= {PAIR_COUNT{MODE_DEFAULT}};
      pwr_meta  <= {PAIR_COUNT{PWRDN_DEFAULT}};
      pwr_sync  <= {PAIR_COUNT{PWRDN_DEFAULT}};
      odd_meta  <= {PAIR_COUNT{PWRDN_DEFAULT}};
      odd_sync  <= {PAIR_COUNT{PWRDN_DEFAULT}};
    end else begin
      mode_meta <= pair_lane_mode_strap_i;
      mode_sync <= mode_meta;
      pwr_meta  <= pair_power_down_strap_i;
      pwr_sync  <= pwr_meta;
      odd_meta  <= odd_port_power_down_strap_i;
      odd_sync  <= odd_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // capture sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,   // counting edges after release
    ST_HELD = 2'b01    // straps captured, pins ignored
  } cap_state_e;

  cap_state_e cap_state;
  cap_state_e next_cap_state;
  logic [3:0] edge_cnt;        // edges since reset release
  logic       capture;         // one-cycle capture strobe

  // capture on the tenth edge; the board keeps the straps steady that long
  // edge_cnt stops one past the capture count, so four bits are plenty
  assign capture = (cap_state == ST_WAIT) && (edge_cnt == SAMPLE_EDGE - 4'h1);

  always_comb begin
    next_cap_state = cap_state;
    case (cap_state)
      ST_WAIT: begin
        if (capture) begin
          next_cap_state = ST_HELD;
        end
      end
      ST_HELD: begin
        next_cap_state = ST_HELD;  // only reset leaves this state
      end
      default: begin
        next_cap_state = ST_WAIT;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cap_state <= ST_WAIT;
    end else begin
      cap_state <= next_cap_state;
    end
  end

  // edge counter, frozen once held
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      edge_cnt <= 4'h0;
    end else if (cap_state == ST_WAIT) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // held strap values
  // ---------------------------------------------------------------------------
  // note: the synchroniser adds two cycles of latency, so the captured value
  // reflects the pin about eight edges after release, inside the hold window
  logic [PAIR_COUNT-1:0] mode_held;
  logic [PAIR_COUNT-1:0] pwr_held;
  logic [PAIR_COUNT-1:0] odd_held;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_held <= {PAIR_COUNT{MODE_DEFAULT}};
      pwr_held  <= {PAIR_COUNT{PWRDN_DEFAULT}};
      odd_held  <= {PAIR_COUNT{PWRDN_DEFAULT}};
    end else if (capture) begin
      // loaded once; later pin activity never reaches these flops
      mode_held <= mode_sync;
      pwr_held  <= pwr_sync;
      odd_held  <= odd_sync;
    end
  end

  // config is only trusted after capture
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_valid_o <= 1'b0;
    end else begin
      cfg_valid_o <= (next_cap_state == ST_HELD);
    end
  end

  // ---------------------------------------------------------------------------
  // apb registers: one clock-select word per pair
  // ---------------------------------------------------------------------------
  logic [1:0] clksel [PAIR_COUNT];  // {override value, override enable}
  logic       apb_access;           // access phase
  logic       hit_clksel;
  logic       hit_status;
  logic [2:0] reg_idx;

  assign apb_access = psel && penable;
  assign reg_idx    = paddr[4:2];
  assign hit_clksel = (paddr[7:5] == CLKSEL_BASE[7:5]) && (paddr[1:0] == 2'h0);
  assign hit_status = (paddr == STATUS_ADDR);

  // writes land in the access phase; zero wait states
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < PAIR_COUNT; i++) begin
        clksel[i] <= CLKSEL_RESET;
      end
    end else if (apb_access && pwrite && hit_clksel) begin
      clksel[reg_idx] <= pwdata[1:0];
    end
  end

  // read data registered during setup so it is ready in the access phase
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (hit_clksel) begin
        prdata <= {30'h0, clksel[reg_idx]};
      end else if (hit_status) begin
        // held straps and capture flag, software sees the sampled state
        prdata <= {7'h0, cfg_valid_o, odd_held, pwr_held, mode_held};
      end else begin
        prdata <= 32'h0;  // unmapped reads zero
      end
    end
  end

  // ready and error raised for the access phase only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hit_clksel || (hit_status && !pwrite));
    end
  end

  // ---------------------------------------------------------------------------
  // effective power-down and per-pair decode
  // ---------------------------------------------------------------------------
  logic [PAIR_COUNT-1:0]   pwr_eff;   // after software override
  logic [PAIR_COUNT-1:0]   next_even_up;
  logic [PAIR_COUNT-1:0]   next_odd_up;
  logic [PAIR_COUNT-1:0]   next_odd_avail;
  logic [4*PAIR_COUNT-1:0] next_lane_pwr;
  logic [4*PAIR_COUNT-1:0] next_even_sel;
  logic [4*PAIR_COUNT-1:0] next_odd_sel;

  genvar p;
  generate
    for (p = 0; p < PAIR_COUNT; p++) begin : g_pair
      // software override wins over the sampled strap
      assign pwr_eff[p] = clksel[p][OVR_EN_BIT] ? clksel[p][OVR_VAL_BIT]
                                                : pwr_held[p];

      pair_lane_cfg u_cfg (
        .lane_mode_i     (mode_held[p]),
        .pair_pwrdn_i    (pwr_eff[p]),
        .odd_pwrdn_i     (odd_held[p]),
        .even_up_o       (next_even_up[p]),
        .odd_up_o        (next_odd_up[p]),
        .odd_avail_o     (next_odd_avail[p]),
        .lane_pwr_o      (next_lane_pwr[4*p +: 4]),
        .even_lane_sel_o (next_even_sel[4*p +: 4]),
        .odd_lane_sel_o  (next_odd_sel[4*p +: 4])
      );
    end
  endgenerate

  // register outputs; everything powered down until capture completes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      even_port_up_o   <= '0;
      odd_port_up_o    <= '0;
      odd_port_avail_o <= '0;
      lane_power_o     <= '0;
      even_lane_sel_o  <= '0;
      odd_lane_sel_o   <= '0;
    end else if (cap_state == ST_HELD) begin
      even_port_up_o   <= next_even_up;
      odd_port_up_o    <= next_odd_up;
      odd_port_avail_o <= next_odd_avail;
      lane_power_o     <= next_lane_pwr;
      even_lane_sel_o  <= next_even_sel;
      odd_lane_sel_o   <= next_odd_sel;
    end
  end

  // ---------------------------------------------------------------------------
  // test-mode pin drive
  // ---------------------------------------------------------------------------
  // the enables are flops so the pads never glitch out of test mode
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pair_lane_mode_strap_oe_o  <= '0;
      pair_power_down_strap_oe_o <= '0;
      pair_lane_mode_strap_o     <= '0;
      pair_power_down_strap_o    <= '0;
    end else begin
      pair_lane_mode_strap_oe_o  <= {PAIR_COUNT{test_mode_i}};
      pair_power_down_strap_oe_o <= {PAIR_COUNT{test_mode_i}};
      pair_lane_mode_strap_o     <= strap_test_data_i;
      pair_power_down_strap_o    <= strap_test_data_i;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  // pair 0 stands for all pairs; the generate loop makes them identical
  a_capture_edge: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(cfg_valid_o) |-> $past(edge_cnt) == SAMPLE_EDGE - 4'h1)
    else $error("capture not on tenth edge");

  a_held_stable: assert property (@(posedge clk_i) disable iff (reset_i)
    (cap_state == ST_HELD) && $past(cap_state == ST_HELD) |-> $stable(mode_held) && $stable(pwr_held))
    else $error("held strap changed after capture");

  a_lane_a_even: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o |=> even_lane_sel_o[0])
    else $error("lane a left the even port");

  a_four_lane: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o && !mode_held[0] |=> even_lane_sel_o[3:0] == 4'hF && !odd_port_avail_o[0])
    else $error("four-lane decode wrong");

  a_one_lane: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o && mode_held[0] |=> odd_lane_sel_o[3:0] == 4'h2 && even_lane_sel_o[3:0] == 4'h1)
    else $error("one-lane decode wrong");

  a_pair_down: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o && pwr_eff[0] |=> !even_port_up_o[0] && !odd_port_up_o[0] && lane_power_o[3:0] == 4'h0)
    else $error("pair not powered down");

  a_override_wins: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o && clksel[0][OVR_EN_BIT]
      |=> lane_power_o[3:0] == {4{!$past(clksel[0][OVR_VAL_BIT])}})
    else $error("override ignored");

  a_oe_test_only: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(test_mode_i) |-> pair_lane_mode_strap_oe_o == '0 && pair_power_down_strap_oe_o == '0)
    else $error("strap pin driven outside test mode");

  a_odd_forced_down: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o && !mode_held[0] |=> !odd_port_up_o[0])
    else $error("odd port up in four-lane mode");

  // nothing reaches the ports until the straps are held
  a_off_before_capture: assert property (@(posedge clk_i) disable iff (reset_i)
    !cfg_valid_o |-> lane_power_o == '0 && even_port_up_o == '0 && odd_port_up_o == '0)
    else $error("port configured before capture");

  a_pair_up: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o && !pwr_eff[0] |=> even_port_up_o[0] && lane_power_o[3:0] == 4'hF)
    else $error("pair not powered up");

  a_odd_follows_strap: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_valid_o && mode_held[0] && !pwr_eff[0] |=> odd_port_up_o[0] == !$past(odd_held[0]))
    else $error("odd port ignores its strap");

  c_capture:   cover property (@(posedge clk_i) disable iff (reset_i) $rose(cfg_valid_o));
  c_one_lane:  cover property (@(posedge clk_i) disable iff (reset_i) cfg_valid_o && mode_held[0]);
  c_override:  cover property (@(posedge clk_i) disable iff (reset_i) clksel[0][OVR_EN_BIT]);
  c_apb_write: cover property (@(posedge clk_i) disable iff (reset_i) apb_access && pwrite && pready);
  c_pair_down: cover property (@(posedge clk_i) disable iff (reset_i) cfg_valid_o && pwr_eff[0]);

endmodule : serial_port_lane_strap_config
`default_nettype wire

// ===== sim/strap_board_model.sv
// board side of the strap pins: jumpers, pull resistors and pin resolution
`timescale 1ns/1ps
`default_nettype none

module strap_board_model (
  input  wire logic       drive_en_i,   // jumpers fitted, else resistors only
  input  wire logic [7:0] mode_val_i,   // jumper value, lane-mode pins
  input  wire logic [7:0] pwr_val_i,    // jumper value, pair power-down pins
  input  wire logic [7:0] odd_val_i,    // jumper value, odd power-down pins
  input  wire logic [7:0] mode_dut_i,   // device drive, lane-mode pins
  input  wire logic [7:0] mode_oe_i,    // device enable, lane-mode pins
  input  wire logic [7:0] pwr_dut_i,    // device drive, power-down pins
  input  wire logic [7:0] pwr_oe_i,     // device enable, power-down pins
  output logic      [7:0] mode_pin_o,   // resolved lane-mode pins
  output logic      [7:0] pwr_pin_o,    // resolved power-down pins
  output logic      [7:0] odd_pin_o     // resolved odd power-down pins
);
  // ---------------------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------------------
  // device drive wins over the jumper, a bare pin falls to its resistor
  always_comb begin
    mode_pin_o = (mode_oe_i & mode_dut_i) | (~mode_oe_i & (drive_en_i ? mode_val_i : 8'h00));
    pwr_pin_o  = (pwr_oe_i & pwr_dut_i) | (~pwr_oe_i & (drive_en_i ? pwr_val_i : 8'hFF));
    odd_pin_o  = drive_en_i ? odd_val_i : 8'hFF;
  end
endmodule : strap_board_model

`default_nettype wire

// ===== sim/serial_port_lane_strap_config_test.sv
// self-checking bench for the strap configuration block
`timescale 1ns/1ps
`default_nettype none

module serial_port_lane_strap_config_test
  import strap_cfg_pkg::*;
;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic        clk_i = 1'b0;       // 50 MHz core clock
  logic        reset_i = 1'b1;     // async reset
  logic        test_mode_i = 1'b0; // strap pins become outputs
  logic        drive_en = 1'b1;    // board jumpers fitted
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  mode_v = 8'h00, pwr_v = 8'h00, odd_v = 8'h00, test_d = 8'h00;
  logic [7:0]  hm, hp, ho;         // model: held strap values
  logic [7:0]  ovr_en, ovr_val;    // model: override register fields
  logic [31:0] rd;
  logic        er;
  int          n_errors = 0;
  int          tests_run = 0;
  wire  [7:0]  mode_pin, pwr_pin, odd_pin, mode_o, mode_oe, pwr_o, pwr_oe;
  wire  [7:0]  even_up, odd_up, odd_av;
  wire  [31:0] prdata, lane_pwr, even_sel, odd_sel;
  wire         pready, pslverr, cfg_valid;

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  serial_port_lane_strap_config i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .test_mode_i(test_mode_i), .pair_lane_mode_strap_i(mode_pin),
    .pair_power_down_strap_i(pwr_pin), .odd_port_power_down_strap_i(odd_pin),
    .strap_test_data_i(test_d), .pair_lane_mode_strap_o(mode_o),
    .pair_lane_mode_strap_oe_o(mode_oe), .pair_power_down_strap_o(pwr_o),
    .pair_power_down_strap_oe_o(pwr_oe), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_valid_o(cfg_valid),
    .even_port_up_o(even_up), .odd_port_up_o(odd_up), .odd_port_avail_o(odd_av),
    .lane_power_o(lane_pwr), .even_lane_sel_o(even_sel), .odd_lane_sel_o(odd_sel));

  strap_board_model i_board (.drive_en_i(drive_en), .mode_val_i(mode_v),
    .pwr_val_i(pwr_v), .odd_val_i(odd_v), .mode_dut_i(mode_o), .mode_oe_i(mode_oe),
    .pwr_dut_i(pwr_o), .pwr_oe_i(pwr_oe), .mode_pin_o(mode_pin),
    .pwr_pin_o(pwr_pin), .odd_pin_o(odd_pin));

  // ---------------------------------------------------------------------------
  // comparison and verdict
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------------------
  // apb master: answer awaited, never assumed
  // ---------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    // hold the access phase until pready is sampled high at a rising edge
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ---------------------------------------------------------------------------
  // reference model of every pair
  // ---------------------------------------------------------------------------
  task automatic check_pairs();
    logic e, m;
    for (int p = 0; p < 8; p++) begin
      e = ovr_en[p] ? ovr_val[p] : hp[p];
      m = hm[p];
      check("even_up", even_up[p], !e);
      check("odd_up", odd_up[p], !e && !ho[p] && m);
      check("odd_avail", odd_av[p], m);
      check("lane_power", lane_pwr[4*p+:4], e ? 4'h0 : 4'hF);
      check("even_sel", even_sel[4*p+:4], m ? 4'h1 : 4'hF);
      check("odd_sel", odd_sel[4*p+:4], m ? 4'h2 : 4'h0);
    end
    check("pins_oe", {mode_oe, pwr_oe}, 16'h0);
  endtask : check_pairs

  // reset, then capture on the tenth edge with pins held meanwhile
  task automatic do_reset();
    @(posedge clk_i);
    reset_i <= 1'b1;
    ovr_en  = 8'h00;
    ovr_val = 8'h00;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    hm = drive_en ? mode_v : 8'h00;
    hp = drive_en ? pwr_v : 8'hFF;
    ho = drive_en ? odd_v : 8'hFF;
    repeat (9) @(posedge clk_i);
    @(negedge clk_i);
    check("cfg_early", cfg_valid, 1'b0);
    @(negedge clk_i);
    check("cfg_valid", cfg_valid, 1'b1);
    @(negedge clk_i);
  endtask : do_reset

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h5853));
    for (int r = 0; r < 6; r++) begin
      drive_en <= (r != 5); // last round: resistors only
      mode_v   <= 8'($urandom);
      pwr_v    <= (r == 0) ? 8'h00 : 8'($urandom);
      odd_v    <= 8'($urandom);
      do_reset();
      check_pairs();
      apb(1'b0, STATUS_ADDR, 32'h0);
      check("status", rd, {7'h0, 1'b1, ho, hp, hm});
      // pins flip after capture, held values must not
      mode_v <= ~mode_v;
      pwr_v  <= ~pwr_v;
      odd_v  <= ~odd_v;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      check_pairs();
      for (int p = 0; p < 8; p++) begin
        ovr_en[p]  = 1'($urandom);
        ovr_val[p] = 1'($urandom);
        apb(1'b1, 8'(CLKSEL_BASE + 4 * p), {30'h0, ovr_val[p], ovr_en[p]});
        check("clksel_err", er, 1'b0);
      end
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      check_pairs();
      for (int p = 0; p < 8; p++) begin
        apb(1'b0, 8'(CLKSEL_BASE + 4 * p), 32'h0);
        check("clksel", rd, {30'h0, ovr_val[p], ovr_en[p]});
      end
    end
    // refused transfers: unmapped address and read-only status
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    check("unmapped_wr", er, 1'b1);
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped_rd_err", er, 1'b1);
    check("unmapped_rd", rd, 32'h0);
    apb(1'b1, STATUS_ADDR, 32'h0);
    check("status_wr", er, 1'b1);
    // test mode turns the strap pins round, then back
    test_mode_i <= 1'b1;
    test_d      <= 8'($urandom);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check("test_oe", {mode_oe, pwr_oe}, 16'hFFFF);
    check("test_pins", {mode_pin, pwr_pin}, {test_d, test_d});
    @(posedge clk_i);
    test_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check_pairs();
    results();
  end

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    results();
  end
endmodule : serial_port_lane_strap_config_test

`default_nettype wire
